// >>> gpch_byte_reg.sv
// Byte-wide read/write configuration register with write strobe
`timescale 1ns/1ps
`default_nettype none

module gpch_byte_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	output logic [7:0] q
);

	logic [7:0] val_ff;
	logic [7:0] nxt_val;

	always_comb begin
		nxt_val = val_ff;
		if (wr_en) begin
			nxt_val = wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			val_ff <= RESET_VAL;
		end else begin
			val_ff <= nxt_val;
		end
	end

	assign q = val_ff;

endmodule : gpch_byte_reg

`default_nettype wire

// >>> gpch_cfg_tail.sv
// Config header tail of the graphics function: ROM base, pointers, interrupt bytes
//
// Contract
// - ROM base and reserved bits read zero
// - ROM size mask bits read zero, unwritable
// - ROM enable bit always reads zero
// - Capability pointer at 34h reads DCh
// - Interrupt line byte stores and returns writes
// - Interrupt pin byte reads 01h
// - Minimum grant byte reads 00h
// - Maximum latency byte reads 00h
// - Capability next link reads 00h
// - Capability kind code reads 01h
// - Power capabilities word at DEh reads 0021h
`timescale 1ns/1ps
`default_nettype none

module gpch_cfg_tail (
	input wire logic sys_clk,
	input wire logic rst,
	input wire gpch_pkg::gpch_cfg_req_t cfg_req,
	output gpch_pkg::gpch_cfg_rsp_t cfg_rsp,
	output logic [7:0] interrupt_routing_line
);
	import gpch_pkg::*;

	// ==========================================================
	// Decode
	logic hit_rom;
	logic hit_cap;
	logic hit_irq;
	logic hit_pwr;
	logic any_hit;
	logic line_wr;
	logic [7:0] line_q;

	assign hit_rom = cfg_req.dw_addr == GPCH_OFF_ROM_BASE[7:2];
	assign hit_cap = cfg_req.dw_addr == GPCH_OFF_CAP_START[7:2];
	assign hit_irq = cfg_req.dw_addr == GPCH_OFF_INTR_LINE[7:2];
	assign hit_pwr = cfg_req.dw_addr == GPCH_OFF_PWR_CAP_HDR[7:2];
	assign any_hit = hit_rom | hit_cap | hit_irq | hit_pwr;

	// Only the line byte lane of the interrupt dword is writable
	assign line_wr = cfg_req.valid & cfg_req.write & hit_irq &
		cfg_req.byte_en[GPCH_OFF_INTR_LINE[1:0]];

	gpch_byte_reg #(
		.RESET_VAL(GPCH_INTR_LINE_RST)
	) u_line (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(line_wr),
		.wdata(cfg_req.wdata[8*GPCH_OFF_INTR_LINE[1:0] +: 8]),
		.q(line_q)
	);

	assign interrupt_routing_line = line_q;

	// ==========================================================
	// Read data
	// Everything but the line byte is a constant, so no write path reaches it.
	logic [31:0] rom_word;
	logic [31:0] cap_word;
	logic [31:0] irq_word;
	logic [31:0] pwr_word;
	logic [31:0] read_word;

	always_comb begin
		rom_word = 32'h0000_0000;
		rom_word[31:GPCH_ROM_BASE_LSB] = GPCH_ROM_BASE_VAL;
		rom_word[GPCH_ROM_BASE_LSB-1:GPCH_ROM_MASK_LSB] = GPCH_ROM_MASK_VAL;
		rom_word[GPCH_ROM_MASK_LSB-1:GPCH_ROM_RSVD_LSB] = GPCH_ROM_RSVD_VAL;
		rom_word[GPCH_ROM_EN_BIT] = GPCH_ROM_EN_VAL;
	end

	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[8*GPCH_OFF_CAP_START[1:0] +: 8] = GPCH_CAP_START_VAL;
		irq_word = 32'h0000_0000;
		irq_word[8*GPCH_OFF_INTR_LINE[1:0] +: 8] = line_q;
		irq_word[8*GPCH_OFF_INTR_PIN[1:0] +: 8] = GPCH_INTR_PIN_VAL;
		irq_word[8*GPCH_OFF_MIN_GNT[1:0] +: 8] = GPCH_MIN_GNT_VAL;
		irq_word[8*GPCH_OFF_MAX_LAT[1:0] +: 8] = GPCH_MAX_LAT_VAL;
		pwr_word = 32'h0000_0000;
		pwr_word[7:0] = GPCH_CAP_KIND_VAL;
		pwr_word[15:8] = GPCH_NEXT_LINK_VAL;
		pwr_word[8*GPCH_OFF_PWR_CAP_WORD[1:0] +: 16] = GPCH_PWR_CAPS_VAL;
	end

	always_comb begin
		read_word = 32'h0000_0000;
		if (hit_rom) begin
			read_word = rom_word;
		end else if (hit_cap) begin
			read_word = cap_word;
		end else if (hit_irq) begin
			read_word = irq_word;
		end else if (hit_pwr) begin
			read_word = pwr_word;
		end
	end

	// ==========================================================
	// Response
	// Every request, read or write, mapped or not, is answered one cycle later;
	// claim tells the decoder whether the dword belongs here.
	logic ack_ff;
	logic claim_ff;
	logic [31:0] rdata_ff;
	logic nxt_ack;
	logic nxt_claim;
	logic [31:0] nxt_rdata;

	always_comb begin
		nxt_ack = cfg_req.valid;
		nxt_claim = cfg_req.valid & any_hit;
		nxt_rdata = 32'h0000_0000;
		if (cfg_req.valid && !cfg_req.write) begin
			nxt_rdata = read_word;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
			claim_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= nxt_ack;
			claim_ff <= nxt_claim;
			rdata_ff <= nxt_rdata;
		end
	end

	assign cfg_rsp.ack = ack_ff;
	assign cfg_rsp.claim = claim_ff;
	assign cfg_rsp.rdata = rdata_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_read(logic hit);
		cfg_req.valid && !cfg_req.write && hit;
	endsequence

	sequence s_write(logic hit);
		cfg_req.valid && cfg_req.write && hit;
	endsequence

	sequence s_line_write;
		cfg_req.valid && cfg_req.write && hit_irq && cfg_req.byte_en[0];
	endsequence

	a_rom_base_zero: assert property (s_read(hit_rom) |=>
		ack_ff && rdata_ff[31:18] == 14'h0000 && rdata_ff[10:1] == 10'h000)
		else $error("ROM base or reserved bits not zero");

	a_rom_mask_zero: assert property (s_read(hit_rom) |=>
		rdata_ff[17:11] == 7'h00)
		else $error("ROM size mask bits not zero");

	a_rom_enable_off: assert property (s_read(hit_rom) |=>
		!rdata_ff[0])
		else $error("ROM enable bit set");

	a_cap_pointer: assert property (s_read(hit_cap) |=>
		claim_ff && rdata_ff == 32'h0000_00dc)
		else $error("Capability pointer dword wrong");

	a_line_stores: assert property (s_line_write |=>
		interrupt_routing_line == $past(cfg_req.wdata[7:0]))
		else $error("Interrupt line byte did not keep the write");

	a_line_readback: assert property (s_read(hit_irq) |=>
		rdata_ff[7:0] == $past(interrupt_routing_line))
		else $error("Interrupt line byte not returned on read");

	a_line_holds: assert property (
		!(cfg_req.valid && cfg_req.write && hit_irq && cfg_req.byte_en[0]) |=>
		$stable(interrupt_routing_line))
		else $error("Interrupt line changed without a write");

	a_pin_value: assert property (s_read(hit_irq) |=>
		rdata_ff[15:8] == 8'h01)
		else $error("Interrupt pin byte not 01h");

	a_min_gnt: assert property (s_read(hit_irq) |=>
		rdata_ff[23:16] == 8'h00)
		else $error("Minimum grant byte not 00h");

	a_max_lat: assert property (s_read(hit_irq) |=>
		rdata_ff[31:24] == 8'h00)
		else $error("Maximum latency byte not 00h");

	a_next_link: assert property (s_read(hit_pwr) |=>
		rdata_ff[15:8] == 8'h00)
		else $error("Capability next link not 00h");

	a_cap_kind: assert property (s_read(hit_pwr) |=>
		rdata_ff[7:0] == 8'h01)
		else $error("Capability kind code not 01h");

	a_write_completes: assert property (cfg_req.valid && cfg_req.write |=>
		ack_ff && claim_ff == $past(any_hit) && rdata_ff == 32'h0000_0000)
		else $error("Write not completed normally");

	a_ack_single: assert property (!cfg_req.valid |=> !ack_ff && !claim_ff)
		else $error("Answer without a request");

	a_unmapped_quiet: assert property (cfg_req.valid && !any_hit |=>
		ack_ff && !claim_ff && rdata_ff == 32'h0000_0000)
		else $error("Unmapped access not answered quietly");

	a_pwr_caps: assert property (s_read(hit_pwr) |=>
		rdata_ff[31:16] == 16'h0021)
		else $error("Power capabilities word not 0021h");

endmodule : gpch_cfg_tail

`default_nettype wire

// >>> gpch_host_model.sv
// Host model issuing configuration cycles to the header tail
`timescale 1ns/1ps
`default_nettype none

module gpch_host_model
	import gpch_pkg::*;
(
	input wire logic sys_clk,
	output gpch_pkg::gpch_cfg_req_t cfg_req,
	input wire gpch_pkg::gpch_cfg_rsp_t cfg_rsp
);
	initial cfg_req = '0;

	// ==========================================================
	// One request per call, launched off the falling edge
	// Answer is sampled a half cycle after the edge that takes it
	task automatic access(input logic wr, input logic [7:0] off, input logic [3:0] be,
		input logic [31:0] wd, output gpch_cfg_rsp_t rsp);
		@(negedge sys_clk);
		cfg_req <= '{valid: 1'b1, write: wr, dw_addr: off[7:2], byte_en: be, wdata: wd};
		@(negedge sys_clk);
		cfg_req <= '0;
		rsp = cfg_rsp;
	endtask : access
endmodule : gpch_host_model
`default_nettype wire

// >>> gpch_pkg.sv
// Package: offsets, constant register values and carrier types of the config header tail
package gpch_pkg;

	// ==========================================================
	// Register byte offsets in configuration space
	localparam logic [7:0] GPCH_OFF_ROM_BASE = 8'h30;
	localparam logic [7:0] GPCH_OFF_CAP_START = 8'h34;
	localparam logic [7:0] GPCH_OFF_INTR_LINE = 8'h3c;
	localparam logic [7:0] GPCH_OFF_INTR_PIN = 8'h3d;
	localparam logic [7:0] GPCH_OFF_MIN_GNT = 8'h3e;
	localparam logic [7:0] GPCH_OFF_MAX_LAT = 8'h3f;
	localparam logic [7:0] GPCH_OFF_PWR_CAP_HDR = 8'hdc;
	localparam logic [7:0] GPCH_OFF_PWR_CAP_WORD = 8'hde;

	// ==========================================================
	// Expansion ROM base fields, all hardwired
	localparam int GPCH_ROM_BASE_LSB = 18;
	localparam int GPCH_ROM_MASK_LSB = 11;
	localparam int GPCH_ROM_RSVD_LSB = 1;
	localparam int GPCH_ROM_EN_BIT = 0;
	localparam logic [13:0] GPCH_ROM_BASE_VAL = 14'h0000;
	localparam logic [6:0] GPCH_ROM_MASK_VAL = 7'h00;
	localparam logic [9:0] GPCH_ROM_RSVD_VAL = 10'h000;
	localparam logic GPCH_ROM_EN_VAL = 1'b0;

	// ==========================================================
	// Byte and word register values
	localparam logic [7:0] GPCH_CAP_START_VAL = 8'hdc;
	localparam logic [7:0] GPCH_INTR_LINE_RST = 8'h00;
	localparam logic [7:0] GPCH_INTR_PIN_VAL = 8'h01;
	localparam logic [7:0] GPCH_MIN_GNT_VAL = 8'h00;
	localparam logic [7:0] GPCH_MAX_LAT_VAL = 8'h00;
	localparam logic [7:0] GPCH_NEXT_LINK_VAL = 8'h00;
	localparam logic [7:0] GPCH_CAP_KIND_VAL = 8'h01;
	localparam logic [15:0] GPCH_PWR_CAPS_VAL = 16'h0021;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] dw_addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} gpch_cfg_req_t;

	typedef struct packed {
		logic ack;
		logic claim;
		logic [31:0] rdata;
	} gpch_cfg_rsp_t;

endpackage : gpch_pkg

// >>> graphics_pci_config_header_tail_bench.sv
// Self-checking bench of the config header tail
`timescale 1ns/1ps
`default_nettype none

module graphics_pci_config_header_tail_bench;
	import gpch_pkg::*;
	logic sys_clk;
	logic rst;
	gpch_cfg_req_t cfg_req;
	gpch_cfg_rsp_t cfg_rsp;
	logic [7:0] line_q;
	int num_errors;
	int checked;
	int cycles;
	logic [7:0] ro_off [3] = '{8'h30, 8'h34, 8'hdc};
	logic [31:0] ro_val [3] = '{32'h0000_0000, 32'h0000_00dc, 32'h0021_0001};

	gpch_cfg_tail i_gpch_cfg_tail (.sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .interrupt_routing_line(line_q));
	gpch_host_model i_gpch_host_model (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

	// ==========================================================
	// Comparison and bus helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [7:0] off, input logic [31:0] exp, input logic clm);
		gpch_cfg_rsp_t rsp;
		i_gpch_host_model.access(1'b0, off, 4'hf, 32'h0, rsp);
		check({30'h0, rsp.ack, rsp.claim}, {30'h0, 1'b1, clm});
		check(rsp.rdata, exp);
	endtask : rd

	task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] wd);
		gpch_cfg_rsp_t rsp;
		i_gpch_host_model.access(1'b1, off, be, wd, rsp);
		// Writes answer with zero data even when discarded
		check({30'h0, rsp.ack, rsp.claim}, {30'h0, 2'b11});
		check(rsp.rdata, 32'h0);
	endtask : wr

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		check({24'h0, line_q}, 32'h0);
		rd(GPCH_OFF_INTR_LINE, 32'h0000_0100, 1'b1);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_ro_map();
		rd(GPCH_OFF_ROM_BASE, 32'h0, 1'b1);
		rd(GPCH_OFF_CAP_START, 32'h0000_00dc, 1'b1);
		rd(GPCH_OFF_PWR_CAP_HDR, 32'h0021_0001, 1'b1);
		rd(8'h80, 32'h0, 1'b0);
		$display("test_ro_map done");
	endtask : test_ro_map

	task automatic test_ro_write();
		for (int i = 0; i < 3; i++) begin
			wr(ro_off[i], 4'hf, 32'hffff_ffff);
			rd(ro_off[i], ro_val[i], 1'b1);
		end
		$display("test_ro_write done");
	endtask : test_ro_write

	task automatic test_line();
		wr(GPCH_OFF_INTR_LINE, 4'h1, 32'hffff_ffa5);
		check({24'h0, line_q}, 32'h0000_00a5);
		rd(GPCH_OFF_INTR_LINE, 32'h0000_01a5, 1'b1);
		// Lane 0 disabled: line must hold while upper read-only lanes drop data
		wr(GPCH_OFF_INTR_LINE, 4'he, 32'hffff_ff5a);
		rd(GPCH_OFF_INTR_LINE, 32'h0000_01a5, 1'b1);
		wr(GPCH_OFF_INTR_LINE, 4'hf, 32'h0000_005a);
		check({24'h0, line_q}, 32'h0000_005a);
		$display("test_line done");
	endtask : test_line

	// Mid-run reset must bring the stored line byte back to its reset value
	task automatic test_reset_again();
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		check({24'h0, line_q}, {24'h0, GPCH_INTR_LINE_RST});
		rd(GPCH_OFF_INTR_LINE, 32'h0000_0100, 1'b1);
		$display("test_reset_again done");
	endtask : test_reset_again

	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Clock, timeout and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Whole run needs well under a hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 1000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		rst = 1'b1;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		test_reset();
		test_ro_map();
		test_ro_write();
		test_line();
		test_reset_again();
		report_and_stop();
	end
endmodule : graphics_pci_config_header_tail_bench
`default_nettype wire
